/* File: src/sfes_pkg.sv */
// Constants, opcodes and timing for the serial flash erase/suspend sequencer.
// Assumes a 100 MHz system clock and a separate SPI link clock (mode 0).
// Functional notes
// [RULE1] Opcodes 20h/52h/D8h erase 4K/32K/64K blocks
// [RULE2] Block erase refused while write latch clear
// [RULE3] Three address bytes; extra bytes ignored
// [RULE4] Low address bits inside block disregarded
// [RULE5] Short address or partial byte aborts erase
// [RULE6] Protected or locked target: no erase
// [RULE7] Aborted block erase clears write latch
// [RULE8] Self-timed erase, busy shown, latch cleared
// [RULE9] Failed verify sets program/erase fault flag
// [RULE10] Chip erase under 60h or C7h alike
// [RULE11] Chip erase needs latch, no address
// [RULE12] Any protected sector blocks chip erase
// [RULE13] Partial opcode or byte: no chip erase
// [RULE14] Suspend opcode B0h, trailing data ignored
// [RULE15] Suspend accepted regardless of write latch
// [RULE16] Suspend within latency, flag set, ready
// [RULE17] Partial suspend opcode or byte: no suspend
// [RULE18] Reads of suspended sector give undefined data
// [RULE19] Erase into program-suspended sector aborts, clears latch
// [RULE20] Both suspend flags may be set together
// [RULE21] Reset cancels the suspended operation
// [RULE22] Disallowed opcodes during suspend ignored; a refused block or chip erase frame still clears the write latch
// (the code keeps the latch when a whole, unguarded frame is refused only because of the suspend)
// [RULE23] Array reads stay allowed during suspend
// [RULE24] Resume opcode D0h continues suspended operation
// [RULE25] Count clocked bits per chip select frame
package sfes_pkg;
   // Command opcodes
   localparam logic [7:0] OP_ERASE_4K = 8'h20;
   localparam logic [7:0] OP_ERASE_32K = 8'h52;
   localparam logic [7:0] OP_ERASE_64K = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
   localparam logic [7:0] OP_SUSPEND = 8'hB0;
   localparam logic [7:0] OP_RESUME = 8'hD0;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   // Bit counts on the link
   localparam logic [7:0] OPCODE_BITS = 8'h08;
   localparam logic [7:0] ADDR_DONE_BITS = 8'h20;
   localparam logic [7:0] BIT_COUNT_MAX = 8'hFF;
   // Timing, in microseconds, and cycle counts at 100 MHz
   localparam int CLK_MHZ = 100;
   localparam int BLOCK_ERASE_TIME_US = 50000;
   localparam int CHIP_ERASE_TIME_US = 400000;
   localparam int SUSPEND_LATENCY_US = 20;
   localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
   localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CLK_MHZ;
   localparam int SUSPEND_LATENCY_CYC = SUSPEND_LATENCY_US * CLK_MHZ;
   // Erase timer width
   localparam int TIMER_W = 32;
   // Number of 64 Kbyte sectors
   localparam int SECTORS = 64;
   // Address masks for block sizes
   localparam logic [23:0] MASK_4K = 24'hFFF000;
   localparam logic [23:0] MASK_32K = 24'hFF8000;
   localparam logic [23:0] MASK_64K = 24'hFF0000;
   // Sequencer states
   typedef enum logic [1:0] {
      SFES_IDLE = 2'b00,
      SFES_ERASE = 2'b01,
      SFES_HOLD = 2'b10,
      SFES_SUSP = 2'b11
   } sfes_state_t;
endpackage

/* File: src/sfes_top.sv */
// Erase, chip erase and suspend/resume sequencer behind the SPI pins.
// The SPI front end runs on the link clock; frames cross by toggle handshake.
// Protection, lockdown and array verify are inputs from the rest of the die.
`timescale 1ns/1ps
module sfes_top #(
   parameter int BLOCK_CYC = sfes_pkg::BLOCK_ERASE_CYC, // Shorten in sim
   parameter int CHIP_CYC = sfes_pkg::CHIP_ERASE_CYC, // Shorten in sim
   parameter int SUSP_CYC = sfes_pkg::SUSPEND_LATENCY_CYC // Shorten in sim
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic [sfes_pkg::SECTORS-1:0] sector_protected_i,
   input wire logic [sfes_pkg::SECTORS-1:0] sector_locked_i,
   input wire logic program_suspended_i,
   input wire logic [5:0] program_sector_i,
   input wire logic erase_verify_fail_i,
   input wire logic [5:0] read_sector_i,
   output logic write_latch_flag_o,
   output logic ready_busy_flag_o,
   output logic erase_suspended_flag_o,
   output logic program_suspended_flag_o,
   output logic program_erase_fault_flag_o,
   output logic erase_start_o,
   output logic [23:0] erase_addr_o,
   output logic [23:0] erase_mask_o,
   output logic chip_erase_o,
   output logic read_undefined_o
);
   import sfes_pkg::*;

   // ---- Link domain: shift opcode and address, count bits ----
   // The link clock only runs inside a frame, so nothing here can wait
   // for a later edge. Every value the system side needs is frozen by
   // the time chip select rises. The frame-end flop then clocks on that
   // rising edge and flips the toggle that crosses to the system clock.
   // Limitation: the bit counter saturates, so a frame of 256 bits or
   // more no longer reads as whole bytes. Such a frame is refused, which
   // is the safe side for an erase.
   logic [7:0] bit_cnt_reg; // Bits clocked this frame
   logic [31:0] shift_reg; // Opcode and address, msb first
   logic [7:0] frame_op_reg; // Captured opcode
   logic [23:0] frame_addr_reg; // Captured address
   logic [7:0] frame_bits_reg; // Bit count held for the system side
   logic frame_tgl_reg; // Flips once per completed frame

   wire [7:0] bit_cnt_next = (bit_cnt_reg == BIT_COUNT_MAX) ? bit_cnt_reg : bit_cnt_reg + 8'h01;
   wire [31:0] shift_next = {shift_reg[30:0], spi_mosi_i};

   // Count bits while chip select is low; restart on every new frame
   always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         bit_cnt_reg <= 8'h00; // [RULE25]
      end else begin
         bit_cnt_reg <= bit_cnt_next; // [RULE25]
      end
   end

   // Shift; opcode and address latched as their last bit arrives
   always_ff @(posedge spi_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= 32'h0000_0000;
         frame_op_reg <= 8'h00;
         frame_addr_reg <= 24'h000000;
      end else begin
         shift_reg <= shift_next;
         if (bit_cnt_reg == OPCODE_BITS - 8'h01) begin
            frame_op_reg <= shift_next[7:0];
         end
         if (bit_cnt_reg == ADDR_DONE_BITS - 8'h01) begin
            frame_addr_reg <= shift_next[23:0]; // [RULE3]
         end
      end
   end

   // Frame end: link clock stops with chip select, so the rising cs edge
   // itself clocks the snapshot and the toggle.
   always_ff @(posedge spi_cs_n_i or posedge rst_i) begin
      if (rst_i) begin
         frame_bits_reg <= 8'h00;
         frame_tgl_reg <= 1'b0;
      end else begin
         frame_bits_reg <= bit_cnt_reg;
         frame_tgl_reg <= ~frame_tgl_reg;
      end
   end

   // ---- Crossing into the system clock ----
   logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg; // Toggle synchroniser
   logic vfail_s1_reg, vfail_s2_reg; // Verify result synchroniser
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
         vfail_s1_reg <= 1'b0;
         vfail_s2_reg <= 1'b0;
      end else begin
         tgl_s1_reg <= frame_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         vfail_s1_reg <= erase_verify_fail_i;
         vfail_s2_reg <= vfail_s1_reg;
      end
   end
   // Snapshot words are stable long before the toggle is seen
   wire frame_done = tgl_s2_reg ^ tgl_s3_reg;

   // ---- Frame decode ----
   // All decode reads the frozen snapshot words. They only change when
   // the next frame passes its eighth or last address bit, or ends, which is far
   // behind the toggle that is already being decoded.
   // A frame that never reached its eighth bit carries no opcode. The
   // opcode register still holds the last frame's opcode, so every
   // command match is gated by op_seen to keep a stale opcode inert.
   wire op_seen = (frame_bits_reg >= OPCODE_BITS);
   wire byte_ok = (frame_bits_reg[2:0] == 3'b000);
   wire op_ok = byte_ok && (frame_bits_reg >= OPCODE_BITS); // [RULE13] [RULE17]
   wire addr_ok = byte_ok && (frame_bits_reg >= ADDR_DONE_BITS); // [RULE5]
   wire is_blk = op_seen && ((frame_op_reg == OP_ERASE_4K) || (frame_op_reg == OP_ERASE_32K)
      || (frame_op_reg == OP_ERASE_64K)); // [RULE1]
   wire is_chip = op_seen && ((frame_op_reg == OP_CHIP_ERASE_A)
      || (frame_op_reg == OP_CHIP_ERASE_B)); // [RULE10]
   wire is_susp = op_seen && (frame_op_reg == OP_SUSPEND); // [RULE14]
   wire is_res = op_seen && (frame_op_reg == OP_RESUME); // [RULE24]
   wire is_wren = op_seen && (frame_op_reg == OP_WRITE_ENABLE);
   wire [23:0] blk_mask = (frame_op_reg == OP_ERASE_4K) ? MASK_4K :
      (frame_op_reg == OP_ERASE_32K) ? MASK_32K : MASK_64K; // [RULE4]
   // Sixty-four sectors of 64 Kbyte: the sector is address bits 21 to 16
   wire [5:0] tgt_sector = frame_addr_reg[21:16];
   wire tgt_guarded = sector_protected_i[tgt_sector] || sector_locked_i[tgt_sector];
   wire any_guarded = (|sector_protected_i) || (|sector_locked_i);
   // Erase into the program-suspended sector is refused
   wire tgt_prog_susp = program_suspended_i && (program_sector_i == tgt_sector);

   // ---- Sequencer ----
   // Idle takes commands, erase counts the self-timed cycle down, hold
   // waits out the suspend latency, and the erase-suspended flag marks
   // an erase parked in idle. The timer is never reloaded on resume, so
   // a resumed erase only runs for the time it still had left.
   // Trade-off: one erase time covers all three block sizes, which keeps
   // a single timer at the cost of finishing small blocks late.
   sfes_state_t state_reg, state_next;
   logic [TIMER_W-1:0] timer_reg, timer_next; // Erase cycles remaining
   logic [TIMER_W-1:0] susp_cnt_reg, susp_cnt_next; // Suspend latency count
   logic wel_reg, wel_next;
   logic es_reg, es_next;
   logic fault_reg, fault_next;
   logic start_reg, start_next;
   logic chip_reg, chip_next;
   logic [23:0] addr_reg, addr_next;
   logic [23:0] mask_reg, mask_next;
   logic undef_reg;
   logic [5:0] susp_sector_reg, susp_sector_next; // Sector held by erase suspend

   // Next-state and flag logic
   always_comb begin
      state_next = state_reg;
      timer_next = timer_reg;
      susp_cnt_next = susp_cnt_reg;
      wel_next = wel_reg;
      es_next = es_reg;
      fault_next = fault_reg;
      start_next = 1'b0;
      chip_next = chip_reg;
      addr_next = addr_reg;
      mask_next = mask_reg;
      susp_sector_next = susp_sector_reg;
      case (state_reg)
         SFES_IDLE: begin
            if (frame_done && op_ok && is_wren) begin
               wel_next = 1'b1;
            end else if (frame_done && is_blk) begin
               // Block erase: needs latch, full address, clean target
               if (!addr_ok || tgt_guarded || tgt_prog_susp) begin
                  wel_next = 1'b0; // [RULE7] [RULE6] [RULE19] [RULE5]
               end else if (wel_reg && !es_reg) begin // [RULE2] [RULE22]
                  state_next = SFES_ERASE;
                  timer_next = TIMER_W'(BLOCK_CYC);
                  addr_next = frame_addr_reg & blk_mask; // [RULE4]
                  mask_next = blk_mask;
                  chip_next = 1'b0;
                  start_next = 1'b1; // [RULE1]
                  fault_next = 1'b0;
               end
            end else if (frame_done && is_chip) begin
               if (!byte_ok || any_guarded) begin
                  wel_next = 1'b0; // [RULE12] [RULE13]
               end else if (op_ok && wel_reg && !es_reg && !program_suspended_i) begin // [RULE11] [RULE22]
                  state_next = SFES_ERASE;
                  timer_next = TIMER_W'(CHIP_CYC);
                  addr_next = 24'h000000;
                  mask_next = 24'h000000;
                  chip_next = 1'b1;
                  start_next = 1'b1;
                  fault_next = 1'b0;
               end
            end else if (frame_done && op_ok && is_res && es_reg && !program_suspended_i) begin
               es_next = 1'b0; // [RULE24]
               state_next = SFES_ERASE;
            end
         end
         SFES_ERASE: begin
            // Self-timed; latch drops one cycle after busy rises
            wel_next = 1'b0; // [RULE8]
            if (frame_done && op_ok && is_susp) begin // [RULE14] [RULE15]
               state_next = SFES_HOLD;
               susp_cnt_next = TIMER_W'(SUSP_CYC);
            end else if (timer_reg == '0) begin
               fault_next = vfail_s2_reg; // [RULE9]
               state_next = SFES_IDLE;
            end else begin
               timer_next = timer_reg - TIMER_W'(1);
            end
         end
         SFES_HOLD: begin
            // Suspend latency; timer stays frozen
            if (susp_cnt_reg == '0) begin
               state_next = SFES_IDLE;
               es_next = 1'b1; // [RULE16]
               susp_sector_next = addr_reg[21:16];
            end else begin
               susp_cnt_next = susp_cnt_reg - TIMER_W'(1);
            end
         end
         default: begin
            state_next = SFES_IDLE;
         end
      endcase
   end

   // State registers; reset cancels any suspended erase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= SFES_IDLE;
         timer_reg <= '0;
         susp_cnt_reg <= '0;
         wel_reg <= 1'b0;
         es_reg <= 1'b0; // [RULE21]
         fault_reg <= 1'b0;
         start_reg <= 1'b0;
         chip_reg <= 1'b0;
         addr_reg <= 24'h000000;
         mask_reg <= 24'h000000;
         susp_sector_reg <= 6'h00;
      end else begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         susp_cnt_reg <= susp_cnt_next;
         wel_reg <= wel_next;
         es_reg <= es_next;
         fault_reg <= fault_next;
         start_reg <= start_next;
         chip_reg <= chip_next;
         addr_reg <= addr_next;
         mask_reg <= mask_next;
         susp_sector_reg <= susp_sector_next;
      end
   end

   // Undefined-read marker for the read path
   wire undef_next = (es_reg && (read_sector_i == susp_sector_reg))
      || (program_suspended_i && (read_sector_i == program_sector_i)); // [RULE18] [RULE23]
   logic busy_reg, ps_reg;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         undef_reg <= 1'b0;
         busy_reg <= 1'b0;
         ps_reg <= 1'b0;
      end else begin
         undef_reg <= undef_next;
         busy_reg <= (state_next == SFES_ERASE) || (state_next == SFES_HOLD); // [RULE8]
         ps_reg <= program_suspended_i; // [RULE20]
      end
   end

   assign write_latch_flag_o = wel_reg;
   assign ready_busy_flag_o = busy_reg;
   assign erase_suspended_flag_o = es_reg;
   assign program_suspended_flag_o = ps_reg;
   assign program_erase_fault_flag_o = fault_reg;
   assign erase_start_o = start_reg;
   assign erase_addr_o = addr_reg;
   assign erase_mask_o = mask_reg;
   assign chip_erase_o = chip_reg;
   assign read_undefined_o = undef_reg;

   // ---- Checks ----
   // These watch the sequencer from the system clock only. The link side
   // has no clock outside frames, so its framing is checked through the
   // snapshot words once the toggle has crossed.
   // Each property on a frame waits for frame_done rather than for chip select,
   // because the pin edge is not a sample point of this clock.
   sequence susp_frame_s;
      frame_done && op_ok && is_susp && state_reg == SFES_ERASE;
   endsequence
   sequence hold_end_s;
      state_reg == SFES_HOLD && susp_cnt_reg == '0;
   endsequence
   susp_take_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE14]
      susp_frame_s |=> state_reg == SFES_HOLD)
      else $error("suspend frame not taken");
   susp_ready_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
      hold_end_s |=> !ready_busy_flag_o)
      else $error("suspended erase still busy");
   resume_run_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE24]
      frame_done && op_ok && is_res && es_reg && !program_suspended_i
      && state_reg == SFES_IDLE |=> !erase_suspended_flag_o && ready_busy_flag_o)
      else $error("resume did not restart erase");
   susp_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE22]
      frame_done && op_ok && is_chip && es_reg && !any_guarded && state_reg == SFES_IDLE
      |=> $stable(write_latch_flag_o) && !erase_start_o)
      else $error("chip erase acted during suspend");
   fault_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE9]
      state_reg == SFES_ERASE && timer_reg == '0 && !(frame_done && op_ok && is_susp)
      |=> program_erase_fault_flag_o == $past(vfail_s2_reg))
      else $error("fault flag not from verify");
   undef_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE18]
      es_reg && read_sector_i == susp_sector_reg |=> read_undefined_o)
      else $error("suspended sector read not marked");
   sequence blk_frame_s;
      frame_done && is_blk && !addr_ok && state_reg == SFES_IDLE;
   endsequence
   short_addr_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE5]
      blk_frame_s |=> !write_latch_flag_o && !erase_start_o)
      else $error("short block erase not aborted");
   no_wel_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE2]
      erase_start_o && !chip_erase_o |-> $past(wel_reg))
      else $error("erase started without latch");
   guard_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE6]
      frame_done && is_blk && tgt_guarded && state_reg == SFES_IDLE |=> !erase_start_o)
      else $error("protected block erased");
   busy_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE8]
      erase_start_o |-> ready_busy_flag_o ##1 !write_latch_flag_o)
      else $error("erase not busy or latch kept");
   chip_guard_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
      frame_done && is_chip && any_guarded && state_reg == SFES_IDLE
      |=> !erase_start_o && !write_latch_flag_o)
      else $error("chip erase with protection");
   susp_done_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE16]
      state_reg == SFES_HOLD && susp_cnt_reg == '0 |=> erase_suspended_flag_o)
      else $error("suspend flag not set");
   susp_bad_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE17]
      frame_done && is_susp && !byte_ok && state_reg == SFES_ERASE |=> state_reg != SFES_HOLD)
      else $error("partial suspend acted");
   mask_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE4]
      erase_start_o |-> (erase_addr_o & ~erase_mask_o) == 24'h000000)
      else $error("low address bits kept");
endmodule

/* File: sim/sfes_spi_host.sv */
// Host side of the SPI link: frames of up to 40 bits, msb first, mode 0.
// Called by the bench through its frame task; link clock stands still between frames.
`timescale 1ns/1ps
module sfes_spi_host (
   output logic spi_clk_o,
   output logic spi_cs_n_o,
   output logic spi_mosi_o
);
   // Idle levels before the first frame
   initial begin
      spi_clk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end

   // One frame of nb bits from word bit 39 down, 64 ns link period
   task automatic frame(input logic [39:0] w, input int nb);
      int i;
      spi_cs_n_o = 1'b0;
      for (i = 0; i < nb; i++) begin
         spi_mosi_o = w[39-i];
         #32 spi_clk_o = 1'b1;
         #32 spi_clk_o = 1'b0;
      end
      #32 spi_cs_n_o = 1'b1;
      // Released line must not keep the last bit
      spi_mosi_o = ~spi_mosi_o;
   endtask
endmodule

/* File: sim/serial_flash_erase_suspend_tb.sv */
// Self-checking bench for the erase/suspend sequencer.
// Assumes the design's own assertions and a shortened erase timer.
`timescale 1ns/1ps
module serial_flash_erase_suspend_tb;
   import sfes_pkg::*;
   logic clk, rst, psus, vfail, seen, cap_chip;
   logic [63:0] prot, lock;
   logic [5:0] psec, rsec;
   logic [23:0] eaddr, emask, cap_addr, cap_mask;
   logic wl, busy, esus, psf, fault, start, chip, rund;
   wire sck, csn, mosi;
   int n_fail, check_count;

   // Long enough that a suspend frame lands mid-erase
   sfes_top #(.BLOCK_CYC(2000), .CHIP_CYC(3000), .SUSP_CYC(5)) dut_u (
      .clk_i(clk), .rst_i(rst), .spi_clk_i(sck), .spi_cs_n_i(csn), .spi_mosi_i(mosi),
      .sector_protected_i(prot), .sector_locked_i(lock), .program_suspended_i(psus),
      .program_sector_i(psec), .erase_verify_fail_i(vfail), .read_sector_i(rsec),
      .write_latch_flag_o(wl), .ready_busy_flag_o(busy), .erase_suspended_flag_o(esus),
      .program_suspended_flag_o(psf), .program_erase_fault_flag_o(fault),
      .erase_start_o(start), .erase_addr_o(eaddr), .erase_mask_o(emask),
      .chip_erase_o(chip), .read_undefined_o(rund));
   sfes_spi_host host_u (.spi_clk_o(sck), .spi_cs_n_o(csn), .spi_mosi_o(mosi));

   // System clock, 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Catch the one-cycle start pulse and what it carries
   always @(posedge clk) begin
      if (start === 1'b1) begin
         seen <= 1'b1;
         cap_addr <= eaddr;
         cap_mask <= emask;
         cap_chip <= chip;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Frame, then a gap covering the crossing and the pulse
   task automatic send(input logic [39:0] w, input int nb);
      seen = 1'b0;
      host_u.frame(w, nb);
      cyc(8);
   endtask
   task automatic wen();
      send({OP_WRITE_ENABLE, 32'h0}, 8);
   endtask
   task automatic chk1(input string s, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic chk24(input string s, input logic [23:0] e, input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   // Bounded wait for the erase timer to run out
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy === 1'b1 && k < 5000) begin
         cyc(1);
         k++;
      end
      chk1("busy", 1'b0, busy);
   endtask
   task automatic do_reset();
      rst = 1'b1;
      cyc(10);
      rst = 1'b0;
      cyc(3);
   endtask

   // Each block size, extra byte, unaligned address, fault on the last
   task automatic t_block();
      logic [7:0] ops [3];
      logic [23:0] msk [3];
      int i;
      ops = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K};
      msk = '{MASK_4K, MASK_32K, MASK_64K};
      for (i = 0; i < 3; i++) begin
         vfail = (i == 2);
         wen();
         send({ops[i], 24'h123456, 8'hA5}, 40);
         chk1("start", 1'b1, seen);
         chk24("addr", 24'h123456 & msk[i], cap_addr);
         chk24("mask", msk[i], cap_mask);
         chk1("chip", 1'b0, cap_chip);
         chk1("busy", 1'b1, busy);
         chk1("latch", 1'b0, wl);
         wait_idle();
         cyc(3);
         chk1("fault", (i == 2), fault);
      end
      vfail = 1'b0;
   endtask

   // No latch, short, partial byte, protected, locked, program-suspended
   task automatic t_refuse();
      int nb [5];
      int i;
      nb = '{24, 33, 32, 32, 32};
      send({OP_ERASE_64K, 32'h12345600}, 32);
      chk1("start", 1'b0, seen);
      chk1("latch", 1'b0, wl);
      for (i = 0; i < 5; i++) begin
         prot[18] = (i == 2);
         lock[18] = (i == 3);
         psus = (i == 4);
         psec = 6'h12;
         wen();
         send({OP_ERASE_4K, 32'h12345600}, nb[i]);
         chk1("start", 1'b0, seen);
         chk1("latch", 1'b0, wl);
      end
      prot = '0;
      lock = '0;
      psus = 1'b0;
   endtask

   // Both chip opcodes, then a protected sector and a partial byte
   task automatic t_chip();
      int i;
      for (i = 0; i < 4; i++) begin
         prot[40] = (i == 2);
         wen();
         send({(i == 1) ? OP_CHIP_ERASE_B : OP_CHIP_ERASE_A, 32'hFF000000},
            (i == 3) ? 12 : 16);
         chk1("start", (i < 2), seen);
         chk1("latch", 1'b0, wl);
         if (i < 2) begin
            chk1("chip", 1'b1, cap_chip);
            chk24("addr", 24'h0, cap_addr);
            wait_idle();
         end
      end
      prot = '0;
   endtask

   // Suspend mid-erase without latch, reads, ignored opcode, resume, reset
   task automatic t_susp();
      wen();
      send({OP_ERASE_64K, 32'h12000000}, 32);
      send({OP_SUSPEND, 32'hFFFFFFFF}, 12);
      chk1("busy", 1'b1, busy);
      chk1("esus", 1'b0, esus);
      send({OP_SUSPEND, 32'hFFFFFFFF}, 16);
      cyc(4);
      chk1("busy", 1'b0, busy);
      chk1("esus", 1'b1, esus);
      rsec = 6'h12;
      cyc(4);
      chk1("rund", 1'b1, rund);
      rsec = 6'h13;
      cyc(4);
      chk1("rund", 1'b0, rund);
      wen();
      send({OP_CHIP_ERASE_A, 32'h0}, 8);
      chk1("start", 1'b0, seen);
      chk1("latch", 1'b1, wl);
      psus = 1'b1;
      psec = 6'h20;
      cyc(4);
      chk1("psus", 1'b1, psf);
      chk1("esus", 1'b1, esus);
      psus = 1'b0;
      send({OP_RESUME, 32'h0}, 8);
      chk1("esus", 1'b0, esus);
      chk1("busy", 1'b1, busy);
      send({OP_SUSPEND, 32'h0}, 8);
      cyc(4);
      chk1("esus", 1'b1, esus);
      do_reset();
      chk1("esus", 1'b0, esus);
      chk1("busy", 1'b0, busy);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      prot = '0;
      lock = '0;
      psus = 1'b0;
      psec = 6'h0;
      vfail = 1'b0;
      rsec = 6'h0;
      seen = 1'b0;
      n_fail = 0;
      check_count = 0;
      cyc(10);
      rst = 1'b0;
      cyc(3);
      t_block();
      t_refuse();
      t_chip();
      t_susp();
      test_done();
   end

   // Watchdog, several times the expected run
   initial begin
      #1000000;
      n_fail++;
      test_done();
   end
endmodule
